/* pkg/usd_pkg.sv */
// constants for the shadow receive/transmit data port
package usd_pkg;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam logic [31:0] SHADOW_BASE = 32'h5000_1030;
   localparam logic [31:0] SHADOW_LAST = 32'h5000_106C;
   localparam logic [31:0] SHADOW_RX_TX_DATA_8 = 32'h5000_1050;
   localparam logic [31:0] CTRL_ADDR = 32'h5000_1070;
   localparam logic [31:0] LSTAT_ADDR = 32'h5000_1074;
   localparam logic [31:0] ISTAT_ADDR = 32'h5000_1078;
   localparam logic [31:0] IMASK_ADDR = 32'h5000_107C;
   localparam int unsigned DATA_W = 8;
   // control register fields
   localparam int unsigned CTRL_FIFO_EN = 0;
   localparam int unsigned CTRL_IR_MODE = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // line status fields
   localparam int unsigned LS_RX_VALID = 0;
   localparam int unsigned LS_RX_FULL = 1;
   localparam int unsigned LS_TX_FULL = 2;
   localparam int unsigned LS_TX_EMPTY = 5;
   // event bits, same layout in status and mask
   localparam int unsigned EV_RX_DATA = 0;
   localparam int unsigned EV_OVERRUN = 1;
   localparam int unsigned EV_TX_EMPTY = 2;
   localparam int unsigned EV_TX_DROP = 3;
   localparam int unsigned EV_W = 4;
   localparam logic [3:0] IMASK_RESET = 4'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : usd_pkg

/* hdl/usd_shadow_port.sv */
// shadow receive/transmit data port with ahb-lite register access
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
module usd_shadow_port #(
   parameter int unsigned DEPTH = usd_pkg::FIFO_DEPTH
) (
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic [7:0] RX_SER_BYTE_IN,
   input wire logic RX_SER_VALID_IN,
   input wire logic [7:0] RX_IR_BYTE_IN,
   input wire logic RX_IR_VALID_IN,
   output logic [7:0] TX_BYTE_OUT,
   output logic TX_VALID_OUT,
   input wire logic TX_TAKE_IN,
   output logic RX_DATA_VALID_FLAG_OUT,
   output logic TX_HOLDING_EMPTY_FLAG_OUT,
   output logic FIFO_ENABLE_OUT,
   output logic IR_MODE_OUT,
   output logic IRQ_OUT
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] CAP_FIFO = (AW+1)'(DEPTH);
   localparam logic [AW:0] CAP_ONE = (AW+1)'(1);

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : ptr_inc

   // bus side
   logic pend_q;
   logic wr_q;
   logic [31:0] addr_q;
   logic [1:0] ctrl_q;
   logic [3:0] istat_q;
   logic [3:0] imask_q;
   logic [31:0] rdata_q;
   logic ready_q;

   wire addr_phase = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
   wire is_shadow = (addr_q >= usd_pkg::SHADOW_BASE) && (addr_q <= usd_pkg::SHADOW_LAST)
      && (addr_q[1:0] == 2'h0);
   wire acc_rd = pend_q && !wr_q;
   wire acc_wr = pend_q && wr_q;
   wire fen = ctrl_q[usd_pkg::CTRL_FIFO_EN];
   wire ir_mode = ctrl_q[usd_pkg::CTRL_IR_MODE];
   wire ctrl_wr = acc_wr && (addr_q == usd_pkg::CTRL_ADDR);
   wire flush = ctrl_wr && (HWDATA_IN[usd_pkg::CTRL_FIFO_EN] != fen);

   // receive queue
   logic [7:0] rx_mem [DEPTH];
   logic [AW-1:0] rx_wp_q;
   logic [AW-1:0] rx_rp_q;
   logic [AW:0] rx_cnt_q;

   wire rx_vld = ir_mode ? RX_IR_VALID_IN : RX_SER_VALID_IN;
   wire [7:0] rx_byte = ir_mode ? RX_IR_BYTE_IN : RX_SER_BYTE_IN;
   wire [AW:0] rx_cap = fen ? CAP_FIFO : CAP_ONE;
   wire rx_full = rx_cnt_q == rx_cap;
   wire rx_pop = acc_rd && is_shadow && (rx_cnt_q != '0);
   // fifo on and full: byte lost; fifo off: holding byte replaced
   wire rx_grow = rx_vld && (!rx_full || rx_pop);
   wire rx_store = rx_vld && (!rx_full || rx_pop || !fen);
   wire rx_ovr = rx_vld && rx_full && !rx_pop;
   wire [AW-1:0] rx_widx = fen ? rx_wp_q : '0;
   wire [AW-1:0] rx_ridx = fen ? rx_rp_q : '0;
   wire [AW:0] rx_cnt_d = rx_cnt_q + (AW+1)'(rx_grow) - (AW+1)'(rx_pop);

   // transmit queue
   logic [7:0] tx_mem [DEPTH];
   logic [AW-1:0] tx_wp_q;
   logic [AW-1:0] tx_rp_q;
   logic [AW:0] tx_cnt_q;
   logic [7:0] tx_out_q;
   logic tx_vld_q;

   wire [AW:0] tx_cap = fen ? CAP_FIFO : CAP_ONE;
   wire tx_full = tx_cnt_q == tx_cap;
   wire tx_wr = acc_wr && is_shadow;
   wire tx_move = (tx_cnt_q != '0) && (!tx_vld_q || TX_TAKE_IN);
   wire tx_grow = tx_wr && (!tx_full || tx_move);
   wire tx_store = tx_wr && (!tx_full || tx_move || !fen);
   wire tx_drop = tx_wr && tx_full && !tx_move && fen;
   wire [AW-1:0] tx_widx = fen ? tx_wp_q : '0;
   wire [AW-1:0] tx_ridx = fen ? tx_rp_q : '0;
   wire [AW:0] tx_cnt_d = tx_cnt_q + (AW+1)'(tx_grow) - (AW+1)'(tx_move);
   wire tx_empty_d = (tx_cnt_d == '0);

   // events and read mux
   wire [3:0] ev = {tx_drop, tx_empty_d && (tx_cnt_q != '0), rx_ovr, rx_grow};
   wire istat_rd = acc_rd && (addr_q == usd_pkg::ISTAT_ADDR);
   wire [3:0] istat_d = (istat_rd ? 4'h0 : istat_q) | ev;
   wire [7:0] lstat = {2'h0, (tx_cnt_q == '0), 2'h0, tx_full, rx_full, (rx_cnt_q != '0)};
   wire [7:0] rx_head = (rx_cnt_q != '0) ? rx_mem[rx_ridx] : 8'h00;
   // upper bits of every word read as zero
   wire [31:0] rd_val =
      is_shadow ? {24'h0, rx_head} :
      (addr_q == usd_pkg::CTRL_ADDR) ? {30'h0, ctrl_q} :
      (addr_q == usd_pkg::LSTAT_ADDR) ? {24'h0, lstat} :
      (addr_q == usd_pkg::ISTAT_ADDR) ? {28'h0, istat_q} :
      (addr_q == usd_pkg::IMASK_ADDR) ? {28'h0, imask_q} : 32'h0;

   // one wait state so read data leaves a flip-flop
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         pend_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= 32'h0;
         ready_q <= 1'b1;
         rdata_q <= 32'h0;
      end else begin
         pend_q <= addr_phase && !pend_q;
         ready_q <= !(addr_phase && !pend_q);
         if (addr_phase && !pend_q) begin
            wr_q <= HWRITE_IN;
            addr_q <= HADDR_IN;
         end
         rdata_q <= acc_rd ? rd_val : 32'h0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         ctrl_q <= usd_pkg::CTRL_RESET;
         imask_q <= usd_pkg::IMASK_RESET;
         istat_q <= 4'h0;
      end else begin
         if (ctrl_wr)
            ctrl_q <= HWDATA_IN[1:0];
         if (acc_wr && (addr_q == usd_pkg::IMASK_ADDR))
            imask_q <= HWDATA_IN[3:0];
         istat_q <= istat_d; // set wins over read clear
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (rx_store)
         rx_mem[rx_widx] <= rx_byte;
      if (tx_store)
         tx_mem[tx_widx] <= HWDATA_IN[7:0];
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rx_wp_q <= '0;
         rx_rp_q <= '0;
         rx_cnt_q <= '0;
      end else if (flush) begin
         rx_wp_q <= '0;
         rx_rp_q <= '0;
         rx_cnt_q <= '0;
      end else begin
         if (rx_grow && fen)
            rx_wp_q <= ptr_inc(rx_wp_q);
         if (rx_pop && fen)
            rx_rp_q <= ptr_inc(rx_rp_q);
         rx_cnt_q <= rx_cnt_d;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         tx_wp_q <= '0;
         tx_rp_q <= '0;
         tx_cnt_q <= '0;
         tx_vld_q <= 1'b0;
         tx_out_q <= 8'h00;
      end else if (flush) begin
         tx_wp_q <= '0;
         tx_rp_q <= '0;
         tx_cnt_q <= '0;
         tx_vld_q <= tx_vld_q && !TX_TAKE_IN;
      end else begin
         if (tx_grow && fen)
            tx_wp_q <= ptr_inc(tx_wp_q);
         if (tx_move && fen)
            tx_rp_q <= ptr_inc(tx_rp_q);
         tx_cnt_q <= tx_cnt_d;
         if (tx_move)
            tx_out_q <= tx_mem[tx_ridx];
         tx_vld_q <= tx_move || (tx_vld_q && !TX_TAKE_IN);
      end
   end

   // output flops mirror next state (IRQ_OUT uses the current imask_q) so every pin but the constant HRESP_OUT leaves a register
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         RX_DATA_VALID_FLAG_OUT <= 1'b0;
         TX_HOLDING_EMPTY_FLAG_OUT <= 1'b1;
         FIFO_ENABLE_OUT <= 1'b0;
         IR_MODE_OUT <= 1'b0;
         IRQ_OUT <= 1'b0;
      end else begin
         RX_DATA_VALID_FLAG_OUT <= !flush && (rx_cnt_d != '0);
         TX_HOLDING_EMPTY_FLAG_OUT <= flush || tx_empty_d;
         FIFO_ENABLE_OUT <= ctrl_wr ? HWDATA_IN[usd_pkg::CTRL_FIFO_EN] : fen;
         IR_MODE_OUT <= ctrl_wr ? HWDATA_IN[usd_pkg::CTRL_IR_MODE] : ir_mode;
         IRQ_OUT <= |(istat_d & imask_q);
      end
   end

   assign HRDATA_OUT = rdata_q;
   assign HREADYOUT_OUT = ready_q;
   assign HRESP_OUT = 1'b0;
   assign TX_BYTE_OUT = tx_out_q;
   assign TX_VALID_OUT = tx_vld_q;

   // checks
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   sequence s_addr;
      addr_phase && !pend_q;
   endsequence
   sequence s_answer;
      !HREADYOUT_OUT ##1 HREADYOUT_OUT;
   endsequence

   a_wait_state: assert property (s_addr |=> s_answer)
      else $error("bus answer not after one wait state");
   a_rx_upper_zero: assert property (acc_rd |=> HRDATA_OUT[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_rx_overrun: assert property (rx_vld && rx_full && !rx_pop && !flush
      |=> istat_q[usd_pkg::EV_OVERRUN])
      else $error("overrun not flagged");
   a_rx_keep_full: assert property (fen && rx_vld && rx_full && !rx_pop && !flush
      |=> rx_cnt_q == $past(rx_cnt_q) && rx_wp_q == $past(rx_wp_q))
      else $error("full receive fifo changed on arrival");
   a_rx_overwrite: assert property (!fen && rx_vld && !rx_pop && !flush
      |=> rx_mem[0] == $past(rx_byte) && rx_cnt_q == CAP_ONE)
      else $error("holding byte not replaced");
   a_rx_pop: assert property (fen && rx_pop && !rx_vld && !flush
      |=> rx_cnt_q == $past(rx_cnt_q) - CAP_ONE)
      else $error("read did not remove entry");
   a_rx_source: assert property (rx_store && !flush && ir_mode
      |=> rx_mem[$past(rx_widx)] == $past(RX_IR_BYTE_IN))
      else $error("infrared byte not taken");
   a_tx_clear_empty: assert property (!fen && tx_wr && tx_cnt_q == '0 && !flush
      |=> !TX_HOLDING_EMPTY_FLAG_OUT)
      else $error("write did not clear tx empty");
   a_tx_drop: assert property (tx_drop && !flush
      |=> tx_cnt_q == CAP_FIFO && tx_wp_q == $past(tx_wp_q) ##1 1'b1)
      else $error("write to full fifo not dropped");
   a_tx_depth: assert property (tx_cnt_q <= CAP_FIFO)
      else $error("transmit count beyond depth");
   a_irq_level: assert property (|(istat_q & imask_q) |-> ##[0:1] IRQ_OUT || istat_rd)
      else $error("interrupt not raised");

   // arrival or write into free room, then the count step one cycle later
   sequence s_rx_room;
      rx_vld && !rx_full && !rx_pop && !flush;
   endsequence
   sequence s_rx_counted;
      rx_cnt_q == $past(rx_cnt_q) + CAP_ONE;
   endsequence
   sequence s_tx_room;
      fen && tx_wr && !tx_full && !tx_move && !flush;
   endsequence
   sequence s_tx_counted;
      tx_cnt_q == $past(tx_cnt_q) + CAP_ONE;
   endsequence

   a_ready_pair: assert property (HREADYOUT_OUT == !pend_q)
      else $error("ready and pending disagree");
   a_rdata_idle: assert property (!acc_rd
      |=> HRDATA_OUT == 32'h0)
      else $error("read data not zero outside answer");
   a_rx_count_up: assert property (s_rx_room
      |=> s_rx_counted)
      else $error("receive count did not grow");
   a_rx_flag_set: assert property (rx_vld && !flush
      |=> RX_DATA_VALID_FLAG_OUT)
      else $error("data valid flag not set on arrival");
   a_rx_flag_match: assert property (RX_DATA_VALID_FLAG_OUT == (rx_cnt_q != '0))
      else $error("data valid flag disagrees with queue");
   a_rx_head_read: assert property (acc_rd && is_shadow
      |=> HRDATA_OUT == {24'h0, $past(rx_head)})
      else $error("shadow read not oldest byte");
   a_rx_serial: assert property (rx_store && !flush && !ir_mode
      |=> rx_mem[$past(rx_widx)] == $past(RX_SER_BYTE_IN))
      else $error("serial byte not taken");
   a_rx_wr_order: assert property (fen && rx_store && !flush
      |=> rx_wp_q == ptr_inc($past(rx_wp_q)))
      else $error("receive write pointer not advanced");
   a_rx_rd_order: assert property (fen && rx_pop && !flush
      |=> rx_rp_q == ptr_inc($past(rx_rp_q)))
      else $error("receive read pointer not advanced");
   a_rx_ovr_off: assert property (!fen && rx_vld && rx_full && !rx_pop
      |=> istat_q[usd_pkg::EV_OVERRUN])
      else $error("overwrite did not flag overrun");
   a_tx_count_up: assert property (s_tx_room
      |=> s_tx_counted)
      else $error("transmit write not queued");
   a_tx_overwrite: assert property (!fen && tx_wr && tx_full && !tx_move && !flush
      |=> tx_cnt_q == CAP_ONE && tx_mem[0] == $past(HWDATA_IN[7:0]))
      else $error("pending transmit byte not replaced");
   a_tx_drop_flag: assert property (tx_drop
      |=> istat_q[usd_pkg::EV_TX_DROP])
      else $error("dropped write not flagged");
   a_tx_empty_match: assert property (TX_HOLDING_EMPTY_FLAG_OUT == (tx_cnt_q == '0))
      else $error("transmit empty flag disagrees with queue");
   a_tx_hold: assert property (TX_VALID_OUT && !TX_TAKE_IN
      |=> TX_VALID_OUT && $stable(TX_BYTE_OUT))
      else $error("offered transmit byte not held");
   a_ctrl_copy: assert property (FIFO_ENABLE_OUT == fen && IR_MODE_OUT == ir_mode)
      else $error("control copies disagree");
   a_flush_clear: assert property (flush
      |=> rx_cnt_q == '0 && tx_cnt_q == '0)
      else $error("mode change did not empty queues");
endmodule : usd_shadow_port

/* verification/usd_far_end.sv */
// far-end transceiver model: sends received bytes, takes transmit bytes
`timescale 1ns/1ps
module usd_far_end (
   input wire logic clk_in,
   input wire logic stall_in,
   input wire logic [7:0] tx_byte_in,
   input wire logic tx_valid_in,
   output logic tx_take_out = 1'b0,
   output logic [7:0] ser_byte_out = 8'h00,
   output logic ser_valid_out = 1'b0,
   output logic [7:0] ir_byte_out = 8'h00,
   output logic ir_valid_out = 1'b0
);
   byte unsigned got_q[$];
   // one take pulse then a gap: a slow far end, and a stalled one while stall_in is high
   always @(posedge clk_in) begin
      tx_take_out <= tx_valid_in & ~stall_in & ~tx_take_out;
      if (tx_take_out && tx_valid_in)
         got_q.push_back(tx_byte_in);
   end
   // the unselected path shows a different byte, so a wrong path choice cannot hide
   task automatic send(input logic [7:0] b, input logic ir);
      @(posedge clk_in);
      ser_byte_out <= ir ? ~b : b;
      ir_byte_out <= ir ? b : ~b;
      ser_valid_out <= ~ir;
      ir_valid_out <= ir;
      @(posedge clk_in);
      ser_valid_out <= 1'b0;
      ir_valid_out <= 1'b0;
      ser_byte_out <= ~ser_byte_out;
      ir_byte_out <= ~ir_byte_out;
      #1;
   endtask : send
endmodule : usd_far_end

/* verification/test_uart_shadow_rx_tx_data_port.sv */
// self-checking bench for the shadow receive/transmit data port
`timescale 1ns/1ps
module test_uart_shadow_rx_tx_data_port;
   localparam int DEP = 4;
   logic clk = 0, rst_b = 0, hw = 0, st = 1, ry, irq, rv, te, tv, tk, sv, iv;
   logic [1:0] ht = 0;
   logic [31:0] ha = 0, wd = 0, rd, hs, x;
   logic [7:0] tb, sb, ib;
   logic fe, im, rsp;
   logic [31:0] ra[3] = '{usd_pkg::CTRL_ADDR, usd_pkg::IMASK_ADDR, 32'h5000_1080};
   int n_mismatch = 0, n_tests = 0, cyc = 0;
   int q[$];
   initial forever #12.5 clk = ~clk;
   usd_shadow_port #(.DEPTH(DEP)) u_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(1'b1),
      .HADDR_IN(ha), .HTRANS_IN(ht), .HWRITE_IN(hw), .HSIZE_IN(3'h2), .HWDATA_IN(wd),
      .HREADY_IN(ry), .HRDATA_OUT(rd), .HREADYOUT_OUT(ry), .HRESP_OUT(rsp),
      .RX_SER_BYTE_IN(sb), .RX_SER_VALID_IN(sv), .RX_IR_BYTE_IN(ib), .RX_IR_VALID_IN(iv),
      .TX_BYTE_OUT(tb), .TX_VALID_OUT(tv), .TX_TAKE_IN(tk), .RX_DATA_VALID_FLAG_OUT(rv),
      .TX_HOLDING_EMPTY_FLAG_OUT(te), .FIFO_ENABLE_OUT(fe), .IR_MODE_OUT(im), .IRQ_OUT(irq));
   usd_far_end u_far (.clk_in(clk), .stall_in(st), .tx_byte_in(tb), .tx_valid_in(tv),
      .tx_take_out(tk), .ser_byte_out(sb), .ser_valid_out(sv), .ir_byte_out(ib),
      .ir_valid_out(iv));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   // hready is looked at before the edge that samples it, read data likewise
   task automatic rdy;
      int n;
      @(negedge clk);
      for (n = 0; ry !== 1'b1 && n < 20; n++)
         @(negedge clk);
      hs = rd;
      chk(ry, 1'b1);
      chk(rsp, 1'b0);
      @(posedge clk);
      #1;
   endtask : rdy
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      ha <= a;
      ht <= usd_pkg::HTRANS_NONSEQ;
      hw <= w;
      rdy();
      ht <= 2'h0;
      wd <= d;
      rdy();
   endtask : bus
   task automatic drain;
      st <= 1'b0;
      for (int n = 0; n < 200 && u_far.got_q.size() < q.size(); n++)
         @(posedge clk);
      #1;
      chk(32'(u_far.got_q.size()), 32'(q.size()));
      foreach (q[i])
         chk(32'(u_far.got_q[i]), 32'(q[i]));
      st <= 1'b1;
      q.delete();
      u_far.got_q.delete();
   endtask : drain
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(72));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      bus(usd_pkg::LSTAT_ADDR, 1'b0, 0);
      chk(hs, 32'h1 << usd_pkg::LS_TX_EMPTY);
      foreach (ra[i]) begin
         bus(ra[i], 1'b0, 0);
         chk(hs, 0);
      end
      $display("reset test done");
      u_far.send(8'hA5, 1'b0);
      u_far.send(8'h5A, 1'b0);
      u_far.send(8'h3C, 1'b1);
      chk(irq, 1'b0);
      bus(usd_pkg::ISTAT_ADDR, 1'b0, 0);
      chk(hs[usd_pkg::EV_OVERRUN], 1'b1);
      chk(rv, 1'b1);
      bus(usd_pkg::SHADOW_RX_TX_DATA_8, 1'b0, 0);
      chk(hs, 32'h5A);
      chk(rv, 1'b0);
      bus(usd_pkg::SHADOW_LAST, 1'b0, 0);
      chk(hs, 0);
      $display("rx without fifo done");
      bus(usd_pkg::CTRL_ADDR, 1'b1, 32'h3);
      chk(fe, 1'b1);
      chk(im, 1'b1);
      bus(usd_pkg::IMASK_ADDR, 1'b1, 32'h1 << usd_pkg::EV_OVERRUN);
      for (int i = 0; i <= DEP; i++) begin
         x = $urandom;
         u_far.send(x[7:0], 1'b1);
         if (i < DEP)
            q.push_back(x[7:0]);
      end
      bus(usd_pkg::LSTAT_ADDR, 1'b0, 0);
      chk(hs[usd_pkg::LS_RX_FULL], 1'b1);
      chk(irq, 1'b1);
      bus(usd_pkg::ISTAT_ADDR, 1'b0, 0);
      chk(hs[usd_pkg::EV_OVERRUN], 1'b1);
      chk(irq, 1'b0);
      for (int i = 0; i <= DEP; i++) begin
         bus(usd_pkg::SHADOW_BASE + 32'(12 * i), 1'b0, 0);
         chk(hs, q.size() ? 32'(q.pop_front()) : 0);
      end
      $display("rx with fifo done");
      bus(usd_pkg::CTRL_ADDR, 1'b1, 0);
      chk(fe, 1'b0);
      chk(im, 1'b0);
      chk(te, 1'b1);
      for (int i = 0; i < 3; i++) begin
         x = $urandom;
         bus(usd_pkg::SHADOW_RX_TX_DATA_8, 1'b1, x);
         if (i != 1)
            q.push_back(x[7:0]);
      end
      chk(te, 1'b0);
      drain();
      chk(te, 1'b1);
      $display("tx without fifo done");
      bus(usd_pkg::CTRL_ADDR, 1'b1, 32'h1);
      for (int i = 0; i < DEP + 2; i++) begin
         x = $urandom;
         bus(usd_pkg::SHADOW_BASE + 32'(4 * i), 1'b1, x);
         if (i <= DEP)
            q.push_back(x[7:0]);
      end
      bus(usd_pkg::LSTAT_ADDR, 1'b0, 0);
      chk(hs[usd_pkg::LS_TX_FULL], 1'b1);
      bus(usd_pkg::ISTAT_ADDR, 1'b0, 0);
      chk(hs[usd_pkg::EV_TX_DROP], 1'b1);
      drain();
      $display("tx with fifo done");
      end_sim();
   end
endmodule : test_uart_shadow_rx_tx_data_port
